// ===== rtl/nvmpa_mem.v
`timescale 1ns/100ps
`include "nvmpa_regs.vh"

module nvmpa_mem (
   input  wire       clk,
   input  wire       nrst,
   input  wire       wr_en,
   input  wire [5:0] wr_page,
   input  wire [7:0] wr_lo,
   input  wire [7:0] wr_hi,
   input  wire [6:0] rd_idx_a,
   input  wire [6:0] rd_idx_b,
   output wire [7:0] rd_a,
   output wire [7:0] rd_b
);

   wire [7:0] mem_q [0:127];

   genvar gi;
   generate
      for (gi = 0; gi < 128; gi = gi + 1) begin : g_byte
         reg [7:0] cell_q;
         localparam integer PAGE_IDX = gi / 2;
         // page n owns bytes 2n (low cache byte) and 2n+1 (high cache byte)
         always @(posedge clk) begin
            if (!nrst) begin
               cell_q <= `NVM_BYTE_RESET;
            end else if (wr_en && (wr_page == PAGE_IDX[5:0])) begin
               cell_q <= (gi % 2 == 0) ? wr_lo : wr_hi;
            end
         end
         assign mem_q[gi] = cell_q;
      end
   endgenerate

   // two independent read ports, host side and checksum walker
   assign rd_a = mem_q[rd_idx_a];
   assign rd_b = mem_q[rd_idx_b];

endmodule // nvmpa_mem

// ===== rtl/nvmpa_top.v
`timescale 1ns/100ps
`include "nvmpa_regs.vh"

module nvmpa_top (
   input  wire       CORE_CLK,
   input  wire       NRST,
   input  wire [3:0] HOST_PAGE,
   input  wire [7:0] HOST_OFFSET,
   input  wire       HOST_WR,
   input  wire [7:0] HOST_WDATA,
   input  wire       HOST_RD,
   output wire [7:0] HOST_RDATA,
   output wire       HOST_RVALID
);

   localparam ST_IDLE  = 2'd0;
   localparam ST_ERASE = 2'd1;
   localparam ST_PROG  = 2'd2;
   localparam ST_CSUM  = 2'd3;

   // counts are worked out at integer width, then cut to the counter widths on purpose
   // limitation: an operation time above 16 bits of core cycles would wrap the timer
   localparam integer PROG_CYC_FULL  = `NVM_PROG_CYC;
   localparam integer ERASE_CYC_FULL = `NVM_ERASE_CYC;
   localparam integer READ_CYC_FULL  = `NVM_READ_CYC;
   localparam [15:0]  PROG_CYC       = PROG_CYC_FULL[15:0];
   localparam [15:0]  ERASE_CYC      = ERASE_CYC_FULL[15:0];
   localparam [3:0]   READ_CYC       = READ_CYC_FULL[3:0];

   reg  [7:0]  cache_low_q;
   reg  [7:0]  cache_low_d;
   reg  [7:0]  cache_high_q;
   reg  [7:0]  cache_high_d;
   reg  [5:0]  page_ptr_q;
   reg  [5:0]  page_ptr_d;
   reg  [1:0]  state_q;
   reg  [1:0]  state_d;
   reg  [15:0] timer_q;
   reg  [15:0] timer_d;
   reg  [5:0]  op_page_q;
   reg  [5:0]  op_page_d;
   reg  [7:0]  op_lo_q;
   reg  [7:0]  op_lo_d;
   reg  [7:0]  op_hi_q;
   reg  [7:0]  op_hi_d;
   reg  [6:0]  csum_idx_q;
   reg  [6:0]  csum_idx_d;
   reg  [7:0]  csum_q;
   reg  [7:0]  csum_d;
   reg         csum_good_q;
   reg         csum_good_d;
   reg  [3:0]  rd_cnt_q;
   reg  [3:0]  rd_cnt_d;
   reg  [6:0]  rd_idx_q;
   reg  [6:0]  rd_idx_d;
   reg  [7:0]  rdata_q;
   reg  [7:0]  rdata_d;
   reg         rvalid_q;
   reg         rvalid_d;
   reg         mem_wr;
   reg  [7:0]  reg_rdata;

   wire [7:0]  mem_rd_a;
   wire [7:0]  mem_rd_b;
   wire        sel_page;
   wire        win_hit;
   wire        read_busy;
   wire [7:0]  activity;
   wire [7:0]  command_rb;
   wire [7:0]  trig_rb;
   wire [7:0]  csum_stat;

   // byte-wide checksum step, msb first
   function [7:0] csum_step;
      input [7:0] crc_in;
      input [7:0] data_in;
      reg   [7:0] c;
      integer     k;
      begin
         c = crc_in ^ data_in;
         for (k = 0; k < 8; k = k + 1) begin
            c = c[7] ? ((c << 1) ^ `NVM_CSUM_POLY) : (c << 1);
         end
         csum_step = c;
      end
   endfunction

   // decode of the memory access page
   assign sel_page  = (HOST_PAGE == `NVM_PAGE);
   assign win_hit   = sel_page && (HOST_OFFSET <= `NVM_OFS_WINDOW_LAST);
   assign read_busy = (rd_cnt_q != 4'h0) || (state_q == ST_CSUM);

   // status views built from live state
   assign activity   = {5'h00, (state_q == ST_PROG), (state_q == ST_ERASE), read_busy};
   assign command_rb = {6'h00, (state_q == ST_ERASE), (state_q == ST_PROG)};
   assign trig_rb    = {7'h00, (state_q == ST_CSUM)};
   assign csum_stat  = {6'h00, csum_good_q, (state_q == ST_CSUM)};

   // register read mux for the non-window offsets
   always @* begin
      reg_rdata = 8'h00;
      if (!sel_page) begin
         reg_rdata = 8'h00;
      end else if (HOST_OFFSET == `NVM_OFS_CACHE_LOW) begin
         reg_rdata = cache_low_q;
      end else if (HOST_OFFSET == `NVM_OFS_CACHE_HIGH) begin
         reg_rdata = cache_high_q;
      end else if (HOST_OFFSET == `NVM_OFS_PAGE_PTR) begin
         reg_rdata = {2'b00, page_ptr_q};
      end else if (HOST_OFFSET == `NVM_OFS_COMMAND) begin
         reg_rdata = command_rb;
      end else if (HOST_OFFSET == `NVM_OFS_CSUM_TRIG) begin
         reg_rdata = trig_rb;
      end else if (HOST_OFFSET == `NVM_OFS_ACTIVITY) begin
         reg_rdata = activity;
      end else if (HOST_OFFSET == `NVM_OFS_CSUM_STAT) begin
         reg_rdata = csum_stat;
      end else if (HOST_OFFSET == `NVM_OFS_CSUM_VALUE) begin
         reg_rdata = csum_q;
      end
   end

   // host register writes
   always @* begin
      cache_low_d  = cache_low_q;
      cache_high_d = cache_high_q;
      page_ptr_d   = page_ptr_q;
      if (HOST_WR && sel_page) begin
         if (HOST_OFFSET == `NVM_OFS_CACHE_LOW) begin
            cache_low_d = HOST_WDATA;
         end else if (HOST_OFFSET == `NVM_OFS_CACHE_HIGH) begin
            cache_high_d = HOST_WDATA;
         end else if (HOST_OFFSET == `NVM_OFS_PAGE_PTR) begin
            page_ptr_d = HOST_WDATA[5:0];
         end
      end
   end

   // operation sequencer: erase, program and checksum walk
   always @* begin
      state_d     = state_q;
      timer_d     = timer_q;
      op_page_d   = op_page_q;
      op_lo_d     = op_lo_q;
      op_hi_d     = op_hi_q;
      csum_idx_d  = csum_idx_q;
      csum_d      = csum_q;
      csum_good_d = csum_good_q;
      mem_wr      = 1'b0;
      case (state_q)
         ST_IDLE: begin
            // commands only land while idle, so a slow host cannot corrupt a running page
            if (HOST_WR && sel_page && (HOST_OFFSET == `NVM_OFS_COMMAND)) begin
               // both bits set: erase wins, the program bit is dropped and the page ends erased
               if (HOST_WDATA[`NVM_CMD_ERASE_BIT]) begin
                  state_d   = ST_ERASE;
                  timer_d   = ERASE_CYC - 16'h0001;
                  op_page_d = page_ptr_q;
                  op_lo_d   = `NVM_ERASED_VAL;
                  op_hi_d   = `NVM_ERASED_VAL;
               end else if (HOST_WDATA[`NVM_CMD_PROGRAM_BIT]) begin
                  state_d   = ST_PROG;
                  timer_d   = PROG_CYC - 16'h0001;
                  op_page_d = page_ptr_q;
                  op_lo_d   = cache_low_q;
                  op_hi_d   = cache_high_q;
               end
            end else if (HOST_WR && sel_page && (HOST_OFFSET == `NVM_OFS_CSUM_TRIG)) begin
               if (HOST_WDATA[`NVM_TRIG_CALC_BIT]) begin
                  state_d     = ST_CSUM;
                  csum_idx_d  = 7'h00;
                  csum_d      = `NVM_CSUM_INIT;
                  csum_good_d = 1'b0;
               end
            end
         end
         ST_ERASE, ST_PROG: begin
            // page data is latched at start, cache edits during the wait do not leak in
            if (timer_q == 16'h0000) begin
               mem_wr  = 1'b1;
               state_d = ST_IDLE;
            end else begin
               timer_d = timer_q - 16'h0001;
            end
         end
         ST_CSUM: begin
            if (csum_idx_q == `NVM_LAST_INDEX) begin
               csum_good_d = (csum_q == mem_rd_b);
               state_d     = ST_IDLE;
            end else begin
               csum_d     = csum_step(csum_q, mem_rd_b);
               csum_idx_d = csum_idx_q + 7'h01;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // host read path: window reads take the array access time, registers answer next cycle
   // a read issued while a window read is pending is dropped, the host waits for the answer
   always @* begin
      rd_cnt_d = rd_cnt_q;
      rd_idx_d = rd_idx_q;
      rdata_d  = rdata_q;
      rvalid_d = 1'b0;
      if (rd_cnt_q != 4'h0) begin
         if (rd_cnt_q == 4'h1) begin
            rdata_d  = mem_rd_a;
            rvalid_d = 1'b1;
         end
         rd_cnt_d = rd_cnt_q - 4'h1;
      end else if (HOST_RD) begin
         if (win_hit) begin
            rd_cnt_d = READ_CYC;
            rd_idx_d = HOST_OFFSET[6:0];
         end else begin
            rdata_d  = reg_rdata;
            rvalid_d = 1'b1;
         end
      end
   end

   // state registers
   always @(posedge CORE_CLK) begin
      if (!NRST) begin
         cache_low_q  <= `NVM_BYTE_RESET;
         cache_high_q <= `NVM_BYTE_RESET;
         page_ptr_q   <= 6'h00;
         state_q      <= ST_IDLE;
         timer_q      <= 16'h0000;
         op_page_q    <= 6'h00;
         op_lo_q      <= 8'h00;
         op_hi_q      <= 8'h00;
         csum_idx_q   <= 7'h00;
         csum_q       <= `NVM_CSUM_RESET;
         csum_good_q  <= 1'b0;
         rd_cnt_q     <= 4'h0;
         rd_idx_q     <= 7'h00;
         rdata_q      <= 8'h00;
         rvalid_q     <= 1'b0;
      end else begin
         cache_low_q  <= cache_low_d;
         cache_high_q <= cache_high_d;
         page_ptr_q   <= page_ptr_d;
         state_q      <= state_d;
         timer_q      <= timer_d;
         op_page_q    <= op_page_d;
         op_lo_q      <= op_lo_d;
         op_hi_q      <= op_hi_d;
         csum_idx_q   <= csum_idx_d;
         csum_q       <= csum_d;
         csum_good_q  <= csum_good_d;
         rd_cnt_q     <= rd_cnt_d;
         rd_idx_q     <= rd_idx_d;
         rdata_q      <= rdata_d;
         rvalid_q     <= rvalid_d;
      end
   end

   nvmpa_mem u_mem (
      .clk      (CORE_CLK),
      .nrst     (NRST),
      .wr_en    (mem_wr),
      .wr_page  (op_page_q),
      .wr_lo    (op_lo_q),
      .wr_hi    (op_hi_q),
      .rd_idx_a (rd_idx_q),
      .rd_idx_b (csum_idx_q),
      .rd_a     (mem_rd_a),
      .rd_b     (mem_rd_b)
   );

   assign HOST_RDATA  = rdata_q;
   assign HOST_RVALID = rvalid_q;

endmodule // nvmpa_top

// ===== shared/nvmpa_regs.vh
`ifndef NVMPA_REGS_VH
`define NVMPA_REGS_VH

// host page that holds the memory access registers
`define NVM_PAGE            4'h5

// register offsets within that page
`define NVM_OFS_WINDOW_LAST 8'h7F
`define NVM_OFS_CACHE_LOW   8'h80
`define NVM_OFS_CACHE_HIGH  8'h81
`define NVM_OFS_PAGE_PTR    8'h82
`define NVM_OFS_COMMAND     8'h83
`define NVM_OFS_CSUM_TRIG   8'h84
`define NVM_OFS_ACTIVITY    8'h85
`define NVM_OFS_CSUM_STAT   8'h86
`define NVM_OFS_CSUM_VALUE  8'h87

// field positions
`define NVM_CMD_PROGRAM_BIT 0
`define NVM_CMD_ERASE_BIT   1
`define NVM_TRIG_CALC_BIT   0
`define NVM_ACT_READ_BIT    0
`define NVM_ACT_ERASE_BIT   1
`define NVM_ACT_PROG_BIT    2
`define NVM_CST_BUSY_BIT    0
`define NVM_CST_GOOD_BIT    1

// reset and fill values
`define NVM_BYTE_RESET      8'h00
`define NVM_ERASED_VAL      8'h00
`define NVM_CSUM_RESET      8'h01
`define NVM_CSUM_INIT       8'hFF
`define NVM_CSUM_POLY       8'h07
`define NVM_LAST_INDEX      7'h7F

// timing, core clock period and operation times in ns
`define NVM_CLK_NS          10
`define NVM_T_PROG_NS       8000
`define NVM_T_ERASE_NS      8000
`define NVM_T_READ_NS       40
`define NVM_PROG_CYC        ((`NVM_T_PROG_NS + `NVM_CLK_NS - 1) / `NVM_CLK_NS)
`define NVM_ERASE_CYC       ((`NVM_T_ERASE_NS + `NVM_CLK_NS - 1) / `NVM_CLK_NS)
`define NVM_READ_CYC        ((`NVM_T_READ_NS + `NVM_CLK_NS - 1) / `NVM_CLK_NS)

`endif

// ===== verif/nvm_program_access_regs_bench.sv
`timescale 1ns/100ps
`include "nvmpa_regs.vh"
module nvm_program_access_regs_bench;
   reg          core_clk;
   reg          nrst;
   wire [3:0]   page;
   wire [7:0]   offset;
   wire         wr;
   wire [7:0]   wdata;
   wire         rd;
   wire [7:0]   rdata;
   wire         rvalid;
   integer      n_mismatch;
   integer      samples_checked;

   nvmpa_top i_nvmpa_top (.CORE_CLK(core_clk), .NRST(nrst), .HOST_PAGE(page), .HOST_OFFSET(offset),
      .HOST_WR(wr), .HOST_WDATA(wdata), .HOST_RD(rd), .HOST_RDATA(rdata), .HOST_RVALID(rvalid));
   nvmpa_host i_nvmpa_host (.clk(core_clk), .rdata(rdata), .rvalid(rvalid), .page(page),
      .offset(offset), .wr(wr), .wdata(wdata), .rd(rd));

   // 100 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task close_out;
      begin
         if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task rc(input [7:0] o, input [7:0] exp);
      reg [7:0] d;
      begin
         i_nvmpa_host.rd_reg(`NVM_PAGE, o, d);
         chk(d, exp);
      end
   endtask
   task wr5(input [7:0] o, input [7:0] d);
      i_nvmpa_host.wr_reg(`NVM_PAGE, o, d);
   endtask
   // poll until masked busy bits clear; a bound keeps a stuck flag visible
   task poll(input [7:0] o, input [7:0] m);
      reg [7:0] d;
      integer k;
      begin
         d = m;
         for (k = 0; k < 1000 && (d & m) !== 8'h00; k = k + 1)
            i_nvmpa_host.rd_reg(`NVM_PAGE, o, d);
         chk(d & m, 8'h00);
      end
   endtask
   // checksum of an all-zero array, data bytes add nothing
   function [7:0] crc_zero(input integer n);
      integer i;
      reg [7:0] c;
      begin
         c = `NVM_CSUM_INIT;
         for (i = 0; i < n * 8; i = i + 1)
            c = c[7] ? {c[6:0], 1'b0} ^ `NVM_CSUM_POLY : {c[6:0], 1'b0};
         crc_zero = c;
      end
   endfunction

   task t_reset;
      integer i;
      begin
         for (i = 8'h80; i < 8'h87; i = i + 1)
            rc(i[7:0], 8'h00);
         rc(8'h87, 8'h01);
         rc(8'h00, 8'h00);
      end
   endtask
   task t_regs;
      reg [7:0] d;
      begin
         wr5(8'h80, 8'hA5);
         wr5(8'h81, 8'h5A);
         wr5(8'h82, 8'hFF);
         wr5(8'h7F, 8'h33);
         wr5(8'h90, 8'h11);
         i_nvmpa_host.wr_reg(4'h3, 8'h80, 8'h77);
         rc(8'h80, 8'hA5);
         rc(8'h81, 8'h5A);
         rc(8'h82, 8'h3F);
         rc(8'h7F, 8'h00);
         rc(8'h90, 8'h00);
         i_nvmpa_host.rd_reg(4'h3, 8'h80, d);
         chk(d, 8'h00);
      end
   endtask
   task t_prog;
      begin
         wr5(8'h83, 8'h01);
         // an erase and a cache edit while programming must both leave the page alone
         wr5(8'h83, 8'h02);
         wr5(8'h80, 8'h11);
         rc(8'h85, 8'h04);
         rc(8'h83, 8'h01);
         poll(8'h85, 8'h07);
         rc(8'h7E, 8'hA5);
         rc(8'h7F, 8'h5A);
         rc(8'h7D, 8'h00);
         wr5(8'h83, 8'h00);
         rc(8'h85, 8'h00);
      end
   endtask
   task t_erase;
      begin
         // both command bits set: erase only, cache is nonzero so a program would show
         wr5(8'h83, 8'h03);
         rc(8'h85, 8'h02);
         rc(8'h83, 8'h02);
         poll(8'h85, 8'h07);
         rc(8'h7E, 8'h00);
         rc(8'h7F, 8'h00);
      end
   endtask
   // last byte carries the expected sum, so a bad one clears the match flag
   task t_csum(input [7:0] hi, input [7:0] st);
      begin
         wr5(8'h80, 8'h00);
         wr5(8'h81, hi);
         wr5(8'h83, 8'h01);
         poll(8'h85, 8'h07);
         wr5(8'h84, 8'h01);
         rc(8'h86, 8'h01);
         rc(8'h85, 8'h01);
         poll(8'h86, 8'h01);
         rc(8'h86, st);
         rc(8'h87, crc_zero(127));
         rc(8'h84, 8'h00);
      end
   endtask

   // reset in mid-run brings loaded registers back to their reset values
   task t_rst;
      begin
         @(posedge core_clk) #1;
         nrst = 1'b0;
         repeat (2) @(posedge core_clk);
         #1 nrst = 1'b1;
         rc(8'h81, 8'h00);
         rc(8'h82, 8'h00);
         rc(8'h87, 8'h01);
      end
   endtask

   // reset, then the scenarios in order
   initial begin
      n_mismatch = 0;
      samples_checked = 0;
      nrst = 1'b0;
      repeat (4) @(posedge core_clk);
      #1 nrst = 1'b1;
      t_reset;
      t_regs;
      t_prog;
      t_erase;
      t_csum(crc_zero(127), 8'h02);
      t_csum(~crc_zero(127), 8'h00);
      t_rst;
      close_out;
   end
   // the run needs some 40 us, so 200 us means a hang
   initial begin
      #200000;
      n_mismatch = n_mismatch + 1;
      close_out;
   end
endmodule // nvm_program_access_regs_bench

bind nvmpa_top nvmpa_assertions i_nvmpa_assertions (.CORE_CLK(CORE_CLK), .NRST(NRST), .HOST_PAGE(HOST_PAGE),
   .HOST_OFFSET(HOST_OFFSET), .HOST_WR(HOST_WR), .HOST_WDATA(HOST_WDATA), .HOST_RD(HOST_RD),
   .HOST_RDATA(HOST_RDATA), .HOST_RVALID(HOST_RVALID));

// ===== verif/nvmpa_assertions.sv
`timescale 1ns/100ps
`include "nvmpa_regs.vh"
module nvmpa_assertions (
   input wire       CORE_CLK,
   input wire       NRST,
   input wire [3:0] HOST_PAGE,
   input wire [7:0] HOST_OFFSET,
   input wire       HOST_WR,
   input wire [7:0] HOST_WDATA,
   input wire       HOST_RD,
   input wire [7:0] HOST_RDATA,
   input wire       HOST_RVALID
);
   reg  pend_q;
   wire rd_ok = HOST_RD && !pend_q;
   wire rd5   = rd_ok && HOST_PAGE == `NVM_PAGE;
   // open window read; requests meanwhile are refused, so skip them
   always @(posedge CORE_CLK) begin
      if (!NRST)
         pend_q <= 1'b0;
      else if (rd5 && !HOST_OFFSET[7])
         pend_q <= 1'b1;
      else if (HOST_RVALID)
         pend_q <= 1'b0;
   end
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);
   property p_reg_ans;
      rd5 && HOST_OFFSET[7] |=> HOST_RVALID;
   endproperty
   a_reg_ans: assert property (p_reg_ans) else $error("late register answer");
   property p_win_lat;
      rd5 && !HOST_OFFSET[7] |=> !HOST_RVALID [*4] ##1 HOST_RVALID;
   endproperty
   a_win_lat: assert property (p_win_lat) else $error("window read latency");
   property p_page;
      rd_ok && HOST_PAGE != `NVM_PAGE |=> HOST_RVALID && HOST_RDATA == 8'h00;
   endproperty
   a_page: assert property (p_page) else $error("foreign page answer");
   property p_unmap;
      rd5 && HOST_OFFSET > 8'h87 |=> HOST_RVALID && HOST_RDATA == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped offset answer");
   property p_hold;
      !HOST_RVALID |-> $stable(HOST_RDATA);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_ptr;
      rd5 && HOST_OFFSET == 8'h82 |=> HOST_RDATA[7:6] == 2'b00;
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer reserved bits");
   property p_cmd;
      rd5 && HOST_OFFSET == 8'h83 |=> HOST_RDATA[7:2] == 6'h00;
   endproperty
   a_cmd: assert property (p_cmd) else $error("command reserved bits");
   property p_act;
      rd5 && HOST_OFFSET == 8'h85 |=> HOST_RDATA[7:3] == 5'h00;
   endproperty
   a_act: assert property (p_act) else $error("status reserved bits");
endmodule // nvmpa_assertions

// ===== verif/nvmpa_host.sv
`timescale 1ns/100ps
module nvmpa_host (
   input  wire       clk,
   input  wire [7:0] rdata,
   input  wire       rvalid,
   output reg  [3:0] page,
   output reg  [7:0] offset,
   output reg        wr,
   output reg  [7:0] wdata,
   output reg        rd
);
   // idle bus from time zero
   initial begin
      page = 4'h0;
      offset = 8'h00;
      wr = 1'b0;
      wdata = 8'h00;
      rd = 1'b0;
   end
   // register writes on any page; data inverted once released
   task wr_reg(input [3:0] p, input [7:0] o, input [7:0] d);
      begin
         @(posedge clk) #1;
         page = p;
         offset = o;
         wdata = d;
         wr = 1'b1;
         @(posedge clk) #1;
         wr = 1'b0;
         wdata = ~d;
      end
   endtask
   // one read open at a time; a lost answer leaves unknown data
   task rd_reg(input [3:0] p, input [7:0] o, output [7:0] d);
      integer k;
      begin
         d = 8'hXX;
         k = 0;
         @(posedge clk) #1;
         page = p;
         offset = o;
         rd = 1'b1;
         @(posedge clk) #1;
         rd = 1'b0;
         while (rvalid !== 1'b1 && k < 16) begin
            @(posedge clk) #1;
            k = k + 1;
         end
         if (rvalid === 1'b1)
            d = rdata;
      end
   endtask
endmodule // nvmpa_host
